// ### pia_accept.sv
// Interrupt acceptance and exception entry sequencer
//
// Contract
// - Mode bit picks one or two-bit masking
// - Nonmaskable accepted always, except reset/standby
// - Source enable bit gates each request except nonmaskable
// - Mode 1: mask bit clear accepts selection
// - Single highest-priority winner, others pending
// - Equal levels resolved by fixed order
// - Level 1 beats level 0
// - Mode 0, mask clear: accept all
// - Mode 0, mask set, user clear: level 1
// - Mode 0, both masks set: nonmaskable only
// - Entry waits for current instruction end
// - Push counter and condition codes first
// - Mode 1 entry sets mask bit
// - Mode 0 entry sets both mask bits
// - Give vector, fetch handler, start routine
// - Decision: 2 states external, 1 internal
// - Save, fetch, prefetch states per memory
// - Internal processing 4 states, twice
// - Prefetch step covers two prefetches
// - Wait states lengthen three-state accesses
// - Smaller vector wins; default after reset
// - External inputs map vectors 12 to 19
`include "pia_map.svh"

module pia_accept (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Pins
	input wire logic nmi_pin,
	input wire logic [7:0] external_request_inputs,
	input wire logic hw_standby_pin,
	// Source enables and on-chip requests
	input wire logic [7:0] irq_enable,
	input wire logic [40:0] int_req,
	input wire logic [40:0] int_enable,
	// Priority level settings
	input wire logic [7:0] priority_level_register_a,
	input wire logic [7:0] priority_level_register_b,
	// Processor status and handshake
	input wire logic user_bit_enable,
	input wire logic ccr_mask_i,
	input wire logic user_interrupt_mask_bit,
	input wire logic insn_end,
	input wire pia_pkg::pia_mem_t mem_cfg,
	input wire logic [1:0] wait_states,
	// Exception entry outputs
	output logic accept_r,
	output logic [5:0] vec_num_r,
	output logic entry_busy_r,
	output logic stack_save_r,
	output logic vector_fetch_r,
	output logic prefetch_r,
	output logic set_mask_i_r,
	output logic set_user_mask_r,
	output logic start_routine_r,
	output logic nmi_taken_r
);

	////////////////////////////////////////////////////////////////////////
	// Functions

	// Priority setting bit index of a vector, in {reg_a, reg_b}
	function automatic logic [4:0] ipr_bit(input logic [5:0] v);
		logic [4:0] r;
		r = 5'h10;
		if (v == 6'h0c) begin
			r = 5'h0f;
		end else if (v == 6'h0d) begin
			r = 5'h0e;
		end else if (v == 6'h0e || v == 6'h0f) begin
			r = 5'h0d;
		end else if (v >= 6'h10 && v <= 6'h13) begin
			r = 5'h0c;
		end else if (v == 6'h14 || v == 6'h15) begin
			r = 5'h0b;
		end else if (v >= 6'h18 && v <= 6'h23) begin
			r = 5'h0a - 5'((v - 6'h18) >> 2);
		end else if (v >= 6'h24 && v <= `PIA_VEC_LAST) begin
			r = 5'h07 - 5'((v - 6'h24) >> 2);
		end
		return r;
	endfunction

	// States of one save, fetch or prefetch step
	function automatic logic [4:0] acc_states(input pia_pkg::pia_mem_t m,
		input logic [1:0] w);
		logic [4:0] r;
		r = `PIA_ACC_ONCHIP;
		case (m)
			pia_pkg::PIA_MEM_B8S2: begin
				r = `PIA_ACC_B8S2;
			end
			pia_pkg::PIA_MEM_B8S3: begin
				r = `PIA_ACC_B8S3 + 5'(`PIA_NACC_B8) * 5'(w);
			end
			pia_pkg::PIA_MEM_B16S2: begin
				r = `PIA_ACC_B16S2;
			end
			pia_pkg::PIA_MEM_B16S3: begin
				r = `PIA_ACC_B16S3 + 5'(`PIA_NACC_B16) * 5'(w);
			end
			default: begin
				r = `PIA_ACC_ONCHIP;
			end
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [9:0] sync1_r;
	logic [9:0] sync2_r;
	logic nmi_prev_r;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sync1_r <= 10'h000;
			sync2_r <= 10'h000;
		end else begin
			sync1_r <= {hw_standby_pin, nmi_pin, external_request_inputs};
			sync2_r <= sync1_r;
		end
	end

	logic [7:0] irq_s;
	logic nmi_s;
	logic standby_s;

	assign irq_s = sync2_r[7:0];
	assign nmi_s = sync2_r[8];
	assign standby_s = sync2_r[9];

	////////////////////////////////////////////////////////////////////////
	// Nonmaskable request latch

	logic nmi_pend_r;
	logic nmi_clr;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			nmi_prev_r <= 1'b0;
		end else begin
			nmi_prev_r <= nmi_s;
		end
	end

	// Edge sets, acceptance clears; set wins; standby blocks
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			nmi_pend_r <= 1'b0;
		end else if (standby_s) begin
			nmi_pend_r <= 1'b0;
		end else if (nmi_s && !nmi_prev_r) begin
			nmi_pend_r <= 1'b1;
		end else if (nmi_clr) begin
			nmi_pend_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Request and level vectors

	pia_sel_if sel_if ();

	logic [63:0] req_vec;
	logic [63:0] lvl_vec;
	logic [15:0] ipr_all;

	assign ipr_all = {priority_level_register_a, priority_level_register_b};

	always_comb begin
		req_vec = '0;
		req_vec[`PIA_VEC_NMI] = nmi_pend_r;
		for (int k = 0; k < `PIA_NUM_IRQ; k++) begin
			req_vec[`PIA_VEC_IRQ0 + k] = irq_s[k] && irq_enable[k];
		end
		for (int k = 0; k < `PIA_NUM_INT; k++) begin
			req_vec[`PIA_VEC_INT0 + k] = int_req[k] && int_enable[k];
		end
	end

	always_comb begin
		lvl_vec = '0;
		for (int v = 0; v < 64; v++) begin
			logic [4:0] b;
			b = ipr_bit(6'(v));
			if (!b[4]) begin
				lvl_vec[v] = ipr_all[b[3:0]];
			end
		end
	end

	assign sel_if.req = standby_s ? 64'h0 : req_vec;
	assign sel_if.lvl = lvl_vec;
	assign sel_if.user_bit_enable = user_bit_enable;
	assign sel_if.mask_i = ccr_mask_i;
	assign sel_if.user_interrupt_mask_bit = user_interrupt_mask_bit;

	pia_selector u_sel (
		.s(sel_if.sel)
	);

	////////////////////////////////////////////////////////////////////////
	// Exception entry sequencer

	pia_pkg::pia_state_t state_r;
	pia_pkg::pia_state_t state_nxt;
	logic [4:0] cnt_r;
	logic [4:0] cnt_nxt;
	logic [4:0] step_states;
	logic win_ext;
	logic last;

	assign step_states = acc_states(mem_cfg, wait_states);
	assign win_ext = sel_if.vec == `PIA_VEC_NMI
		|| (sel_if.vec >= `PIA_VEC_IRQ0 && sel_if.vec < `PIA_VEC_INT0);
	assign last = cnt_r == 5'h01;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		if (cnt_r != 5'h00) begin
			cnt_nxt = cnt_r - 5'h01;
		end
		case (state_r)
			pia_pkg::PIA_IDLE: begin
				if (sel_if.hit) begin
					state_nxt = pia_pkg::PIA_DECIDE;
					cnt_nxt = win_ext ? 5'(`PIA_DEC_EXT) : 5'(`PIA_DEC_INT);
				end
			end
			pia_pkg::PIA_DECIDE: begin
				if (!sel_if.hit) begin
					state_nxt = pia_pkg::PIA_IDLE;
				end else if (last) begin
					state_nxt = pia_pkg::PIA_WAIT_INSN;
				end
			end
			pia_pkg::PIA_WAIT_INSN: begin
				if (insn_end) begin
					state_nxt = pia_pkg::PIA_PROC_A;
					cnt_nxt = `PIA_PROC_STATES;
				end
			end
			pia_pkg::PIA_PROC_A: begin
				if (last) begin
					state_nxt = pia_pkg::PIA_SAVE;
					cnt_nxt = step_states;
				end
			end
			pia_pkg::PIA_SAVE: begin
				if (last) begin
					state_nxt = pia_pkg::PIA_VECTOR;
					cnt_nxt = step_states;
				end
			end
			pia_pkg::PIA_VECTOR: begin
				if (last) begin
					state_nxt = pia_pkg::PIA_PREFETCH;
					cnt_nxt = step_states;
				end
			end
			pia_pkg::PIA_PREFETCH: begin
				if (last) begin
					state_nxt = pia_pkg::PIA_PROC_B;
					cnt_nxt = `PIA_PROC_STATES;
				end
			end
			pia_pkg::PIA_PROC_B: begin
				if (last) begin
					state_nxt = pia_pkg::PIA_IDLE;
				end
			end
			default: begin
				state_nxt = pia_pkg::PIA_IDLE;
				cnt_nxt = 5'h00;
			end
		endcase
		if (standby_s) begin
			state_nxt = pia_pkg::PIA_IDLE;
			cnt_nxt = 5'h00;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_r <= pia_pkg::PIA_IDLE;
			cnt_r <= 5'h00;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Winner capture and acceptance

	logic accept_now;
	logic [5:0] vec_hold_r;

	assign accept_now = state_r == pia_pkg::PIA_WAIT_INSN && insn_end && !standby_s;
	assign nmi_clr = accept_now && vec_hold_r == `PIA_VEC_NMI;

	// Track the current winner until acceptance
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			vec_hold_r <= 6'h00;
		end else if (state_r == pia_pkg::PIA_IDLE || state_r == pia_pkg::PIA_DECIDE
			|| (state_r == pia_pkg::PIA_WAIT_INSN && !insn_end)) begin
			if (sel_if.hit) begin
				vec_hold_r <= sel_if.vec;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			accept_r <= 1'b0;
			nmi_taken_r <= 1'b0;
		end else begin
			accept_r <= accept_now;
			nmi_taken_r <= nmi_clr;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			vec_num_r <= 6'h00;
		end else if (accept_now) begin
			vec_num_r <= vec_hold_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Phase strobes to the processor

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			entry_busy_r <= 1'b0;
			stack_save_r <= 1'b0;
			vector_fetch_r <= 1'b0;
			prefetch_r <= 1'b0;
		end else begin
			entry_busy_r <= !(state_nxt == pia_pkg::PIA_IDLE
				|| state_nxt == pia_pkg::PIA_DECIDE
				|| state_nxt == pia_pkg::PIA_WAIT_INSN);
			stack_save_r <= state_nxt == pia_pkg::PIA_SAVE;
			vector_fetch_r <= state_nxt == pia_pkg::PIA_VECTOR;
			prefetch_r <= state_nxt == pia_pkg::PIA_PREFETCH;
		end
	end

	// Mask update after the save completes
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			set_mask_i_r <= 1'b0;
			set_user_mask_r <= 1'b0;
		end else begin
			set_mask_i_r <= state_r == pia_pkg::PIA_SAVE && last;
			set_user_mask_r <= state_r == pia_pkg::PIA_SAVE && last
				&& !user_bit_enable;
		end
	end

	// Service routine starts at end of entry
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			start_routine_r <= 1'b0;
		end else begin
			start_routine_r <= state_r == pia_pkg::PIA_PROC_B && last
				&& !standby_s;
		end
	end

endmodule // pia_accept

// ### pia_map.svh
// Constants for the interrupt acceptance block
`ifndef PIA_MAP_SVH
`define PIA_MAP_SVH

// Vector numbers
`define PIA_VEC_NMI 6'h07
`define PIA_VEC_IRQ0 6'h0c
`define PIA_VEC_INT0 6'h14
`define PIA_VEC_LAST 6'h3c
`define PIA_NUM_IRQ 8
`define PIA_NUM_INT 41

// Priority decision, in states
`define PIA_DEC_EXT 2'h2
`define PIA_DEC_INT 2'h1

// Internal processing, in states
`define PIA_PROC_STATES 5'h04

// Base states of one save, fetch or prefetch step
`define PIA_ACC_ONCHIP 5'h04
`define PIA_ACC_B8S2 5'h08
`define PIA_ACC_B8S3 5'h0c
`define PIA_ACC_B16S2 5'h04
`define PIA_ACC_B16S3 5'h06

// Accesses per step that take wait states
`define PIA_NACC_B8 3'h4
`define PIA_NACC_B16 3'h2

`endif

// ### pia_pkg.sv
// Types for the interrupt acceptance block
package pia_pkg;

	typedef enum logic [7:0] {
		PIA_IDLE = 8'h01,
		PIA_DECIDE = 8'h02,
		PIA_WAIT_INSN = 8'h04,
		PIA_PROC_A = 8'h08,
		PIA_SAVE = 8'h10,
		PIA_VECTOR = 8'h20,
		PIA_PREFETCH = 8'h40,
		PIA_PROC_B = 8'h80
	} pia_state_t;

	typedef enum logic [2:0] {
		PIA_MEM_ONCHIP = 3'h0,
		PIA_MEM_B8S2 = 3'h1,
		PIA_MEM_B8S3 = 3'h2,
		PIA_MEM_B16S2 = 3'h3,
		PIA_MEM_B16S3 = 3'h4
	} pia_mem_t;

endpackage

// ### pia_sel_if.sv
// Request and selection signals between acceptance logic and selector
interface pia_sel_if;
	logic [63:0] req;
	logic [63:0] lvl;
	logic user_bit_enable;
	logic mask_i;
	logic user_interrupt_mask_bit;
	logic hit;
	logic [5:0] vec;

	modport ctl (output req, output lvl, output user_bit_enable, output mask_i,
		output user_interrupt_mask_bit, input hit, input vec);
	modport sel (input req, input lvl, input user_bit_enable, input mask_i,
		input user_interrupt_mask_bit, output hit, output vec);
endinterface

// ### pia_selector.sv
// Masking and fixed-order selection of the winning request
module pia_selector (
	pia_sel_if.sel s
);

	logic [63:0] elig;
	logic hit1;
	logic hit0;
	logic [5:0] vec1;
	logic [5:0] vec0;

	// Level filter per mask mode
	always_comb begin
		elig = '0;
		for (int v = 0; v < 64; v++) begin
			if (v == 7) begin
				elig[v] = s.req[v];
			end else if (s.user_bit_enable) begin
				elig[v] = s.req[v] && !s.mask_i;
			end else if (!s.mask_i) begin
				elig[v] = s.req[v];
			end else if (!s.user_interrupt_mask_bit) begin
				elig[v] = s.req[v] && s.lvl[v];
			end else begin
				elig[v] = 1'b0;
			end
		end
	end

	// Lowest vector wins within a level
	always_comb begin
		hit1 = 1'b0;
		hit0 = 1'b0;
		vec1 = 6'h00;
		vec0 = 6'h00;
		for (int v = 63; v >= 0; v--) begin
			if (elig[v] && (s.lvl[v] || v == 7)) begin
				hit1 = 1'b1;
				vec1 = 6'(v);
			end
			if (elig[v] && !s.lvl[v]) begin
				hit0 = 1'b1;
				vec0 = 6'(v);
			end
		end
	end

	// Level 1 over level 0; one winner only
	always_comb begin
		s.hit = hit1 || hit0;
		s.vec = hit1 ? vec1 : vec0;
	end

endmodule // pia_selector

// ### pia_accept_properties.sv
// Checker for acceptance and exception entry sequencing
module pia_accept_chk (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Watched inputs
	input wire logic hw_standby_pin,
	input wire logic insn_end,
	input wire logic user_bit_enable,
	input wire pia_pkg::pia_mem_t mem_cfg,
	// Watched outputs
	input wire logic accept_r,
	input wire logic [5:0] vec_num_r,
	input wire logic entry_busy_r,
	input wire logic stack_save_r,
	input wire logic vector_fetch_r,
	input wire logic prefetch_r,
	input wire logic set_mask_i_r,
	input wire logic set_user_mask_r,
	input wire logic start_routine_r,
	input wire logic nmi_taken_r
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn || hw_standby_pin);
	////////////////////////////////////////////////////////////////
	sequence s_proc4;
		(!stack_save_r)[*4] ##1 stack_save_r;
	endsequence
	sequence s_save4;
		stack_save_r[*4] ##1 !stack_save_r;
	endsequence
	sequence s_tail4;
		(!start_routine_r)[*4] ##1 start_routine_r;
	endsequence
	////////////////////////////////////////////////////////////////
	one_winner_a: assert property (accept_r |-> !$past(entry_busy_r))
		else $error("acceptance during entry");
	insn_end_a: assert property (accept_r |-> $past(insn_end))
		else $error("acceptance before instruction end");
	nmi_vec_a: assert property (nmi_taken_r |-> accept_r && vec_num_r == 6'h07)
		else $error("nonmaskable vector wrong");
	proc_a_a: assert property (accept_r |-> s_proc4)
		else $error("first internal step length wrong");
	save_len_a: assert property ($rose(stack_save_r) && mem_cfg == pia_pkg::PIA_MEM_ONCHIP
		|-> s_save4)
		else $error("save step length wrong");
	mask_set_a: assert property ($fell(stack_save_r) |-> set_mask_i_r && vector_fetch_r)
		else $error("mask update not after save");
	user_mask_a: assert property (set_mask_i_r |-> set_user_mask_r == !user_bit_enable)
		else $error("user mask update wrong");
	fetch_pf_a: assert property ($fell(vector_fetch_r) |-> prefetch_r)
		else $error("prefetch not after vector fetch");
	proc_b_a: assert property ($fell(prefetch_r) |-> s_tail4)
		else $error("routine start timing wrong");
	vec_hold_a: assert property ($changed(vec_num_r) |-> accept_r)
		else $error("vector changed without acceptance");
	standby_a: assert property (@(posedge mclk) disable iff (!rstn)
		hw_standby_pin[*5] |-> !entry_busy_r && !accept_r)
		else $error("activity during standby");
endmodule // pia_accept_chk

bind pia_accept pia_accept_chk u_chk (.*);

// ### pia_core_model.sv
// Processor core stand-in: instruction ends and status mask bits
module pia_core_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Bench control
	input wire logic slow,
	input wire logic ld,
	input wire logic ld_i,
	input wire logic ld_ui,
	// Entry strobes
	input wire logic set_mask_i_r,
	input wire logic set_user_mask_r,
	// Core status
	output logic insn_end,
	output logic ccr_mask_i,
	output logic user_interrupt_mask_bit
);
	logic [1:0] cyc_r;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) cyc_r <= 2'h0;
		else cyc_r <= cyc_r + 2'h1;
	end
	// Slow core ends an instruction every fourth cycle
	assign insn_end = !slow || cyc_r == 2'h3;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ccr_mask_i <= 1'b0;
			user_interrupt_mask_bit <= 1'b0;
		end else if (ld) begin
			ccr_mask_i <= ld_i;
			user_interrupt_mask_bit <= ld_ui;
		end else begin
			if (set_mask_i_r) ccr_mask_i <= 1'b1;
			if (set_user_mask_r) user_interrupt_mask_bit <= 1'b1;
		end
	end
endmodule // pia_core_model

// ### tb.sv
// Self-checking bench for the interrupt acceptance block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] %s exp %0h got %0h", n, e, g); end end
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic nmi_pin = 1'b0, hw_standby_pin = 1'b0, user_bit_enable = 1'b1;
	logic slow = 1'b0, ld = 1'b0, ld_i = 1'b0, ld_ui = 1'b0;
	logic [7:0] external_request_inputs = 8'h00, irq_enable = 8'hff;
	logic [7:0] priority_level_register_a = 8'h00, priority_level_register_b = 8'h00;
	logic [40:0] int_req = 41'h0, int_enable = 41'h1ffffffffff;
	pia_pkg::pia_mem_t mem_cfg = pia_pkg::PIA_MEM_ONCHIP;
	logic [1:0] wait_states = 2'h0;
	logic insn_end, ccr_mask_i, user_interrupt_mask_bit, accept_r, entry_busy_r;
	logic stack_save_r, vector_fetch_r, prefetch_r, set_mask_i_r, set_user_mask_r;
	logic start_routine_r, nmi_taken_r;
	logic [5:0] vec_num_r;
	int n_fail = 0, n_checks = 0, n_step = 0, lat;
	always #2.5 mclk = ~mclk;
	pia_accept dut (.*);
	pia_core_model u_core (.*);
	// Step cycles counted from each acceptance
	always @(posedge mclk) n_step <= accept_r ? 0 : n_step + (stack_save_r | vector_fetch_r | prefetch_r);
	////////////////////////////////////////////////////////////////
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic setm(input logic i, input logic ui);
		@(posedge mclk);
		ld <= 1'b1; ld_i <= i; ld_ui <= ui;
		@(posedge mclk);
		ld <= 1'b0;
	endtask
	// Waits for acceptance, drops all requests, waits for the routine start
	task automatic take(input logic [5:0] v, input logic nmi, output int l);
		int i;
		l = 0;
		while (accept_r !== 1'b1 && l < 400) begin @(posedge mclk); #1; l++; end
		`CHK("accept", 1'b1, accept_r)
		`CHK("vector", v, vec_num_r)
		`CHK("nmi taken", nmi, nmi_taken_r)
		if (accept_r !== 1'b1) summarize();
		@(posedge mclk);
		external_request_inputs <= 8'h00; int_req <= 41'h0; nmi_pin <= 1'b0;
		for (i = 0; i < 400 && start_routine_r !== 1'b1; i++) begin @(posedge mclk); #1; end
		`CHK("routine start", 1'b1, start_routine_r)
		if (start_routine_r !== 1'b1) summarize();
	endtask
	task automatic no_take(input int n);
		repeat (n) begin @(posedge mclk); #1; `CHK("no accept", 1'b0, accept_r) end
	endtask
	////////////////////////////////////////////////////////////////
	task automatic s_order;
		setm(0, 0);
		irq_enable <= 8'h28; external_request_inputs <= 8'h2a;
		take(6'h0f, 1'b0, lat);
		`CHK("ext latency", 6, lat)
		setm(0, 0);
		external_request_inputs <= 8'h22;
		take(6'h11, 1'b0, lat);
		irq_enable <= 8'hff;
	endtask
	task automatic s_level;
		setm(0, 0);
		priority_level_register_b <= 8'h02; int_req <= 41'h10000000001;
		take(6'h3c, 1'b0, lat);
		`CHK("int latency", 3, lat)
		priority_level_register_b <= 8'h00;
	endtask
	task automatic s_ue1;
		user_bit_enable <= 1'b1;
		setm(1, 0);
		int_req <= 41'h1;
		no_take(20);
		nmi_pin <= 1'b1;
		take(6'h07, 1'b1, lat);
		`CHK("user mask kept", 1'b0, user_interrupt_mask_bit)
		setm(0, 1);
		int_req <= 41'h1;
		take(6'h14, 1'b0, lat);
		`CHK("mask i", 1'b1, ccr_mask_i)
		`CHK("user mask", 1'b1, user_interrupt_mask_bit)
	endtask
	task automatic s_ue0;
		user_bit_enable <= 1'b0;
		setm(1, 0);
		priority_level_register_a <= 8'h04; int_req <= 41'h11;
		take(6'h18, 1'b0, lat);
		`CHK("mask i", 1'b1, ccr_mask_i)
		`CHK("user mask", 1'b1, user_interrupt_mask_bit)
		setm(1, 0);
		int_req <= 41'h1;
		no_take(20);
		setm(1, 1);
		int_req <= 41'h10;
		no_take(20);
		setm(0, 1);
		int_req <= 41'h1;
		take(6'h14, 1'b0, lat);
		user_bit_enable <= 1'b1; priority_level_register_a <= 8'h00;
	endtask
	task automatic s_mem;
		int exp_s[5] = '{4, 8, 16, 4, 8};
		slow <= 1'b1; wait_states <= 2'h1;
		for (int k = 0; k < 5; k++) begin
			setm(0, 0);
			mem_cfg <= pia_pkg::pia_mem_t'(k); int_req <= 41'h1;
			take(6'h14, 1'b0, lat);
			`CHK("step cycles", 3 * exp_s[k], n_step)
		end
		slow <= 1'b0; wait_states <= 2'h0; mem_cfg <= pia_pkg::PIA_MEM_ONCHIP;
	endtask
	task automatic s_standby;
		setm(0, 0);
		int_req <= 41'h1;
		step(6);
		hw_standby_pin <= 1'b1; nmi_pin <= 1'b1;
		step(10);
		#1 `CHK("entry aborted", 1'b0, entry_busy_r)
		@(posedge mclk);
		hw_standby_pin <= 1'b0; int_req <= 41'h0; nmi_pin <= 1'b0;
		no_take(10);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		step(20);
		rstn <= 1'b1;
		step(1);
		#1 `CHK("reset idle", 1'b0, entry_busy_r | accept_r)
		s_order();
		s_level();
		s_ue1();
		s_ue0();
		s_mem();
		s_standby();
		summarize();
	end
endmodule // tb
